// File: bsq_pkg.sv
// Constants, states and timing for the bus read/write sequencer
package bsq_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int SIZE_W = 2;
    localparam int SAS_W  = 4;
    // One ref_clk period is one clock state, half a bus cycle
    localparam int CLK_PERIOD_NS    = 20;
    localparam int STATES_PER_CYCLE = 2;
    localparam int CI_CYCLES        = 2;
    localparam int CI_STATES        = CI_CYCLES * STATES_PER_CYCLE;
    localparam int DS_LAG_STATES    = STATES_PER_CYCLE;
    localparam logic [SAS_W-1:0] SAS_WRITE = 4'hA;
    localparam logic [SAS_W-1:0] SAS_NOP   = 4'h0;
    localparam logic [SIZE_W-1:0] SIZE_RST = 2'h0;

    typedef enum logic [12:0] {
        ST_IDLE = 13'h0001,
        ST_P0   = 13'h0002,
        ST_P1   = 13'h0004,
        ST_S0   = 13'h0008,
        ST_S1   = 13'h0010,
        ST_S2   = 13'h0020,
        ST_S3   = 13'h0040,
        ST_W1   = 13'h0080,
        ST_W2   = 13'h0100,
        ST_S4   = 13'h0200,
        ST_S5   = 13'h0400,
        ST_V0   = 13'h0800,
        ST_V1   = 13'h1000
    } bsq_state_t;
endpackage : bsq_pkg

// File: bsq_sequencer.sv
// Bus-master sequencer for external read and write transactions
`timescale 1ns/1ps
`default_nettype none
module bsq_sequencer
    import bsq_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic              req_virtual,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [SIZE_W-1:0] req_size,
    input  wire logic [SAS_W-1:0]  req_status,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic [ADDR_W-1:0]      address_bus_out,
    output logic                   address_bus_oe,
    output logic [SIZE_W-1:0]      transfer_size,
    output logic                   rw_out,
    output logic                   cycle_initiate_n,
    output logic                   addr_strobe_n,
    output logic                   data_strobe_n,
    output logic                   data_ready_out_n,
    output logic [SAS_W-1:0]       access_status_code,
    input  wire logic [DATA_W-1:0] data_bus_in,
    output logic [DATA_W-1:0]      data_bus_out,
    output logic                   data_bus_oe,
    input  wire logic              sync_ready_n,
    input  wire logic              async_ack_n
);

    // Pin synchronisers: first stage feeds only the second
    logic              sync_m_reg;
    logic              sync_q_reg;
    logic              async_m_reg;
    logic              async_q_reg;
    logic [DATA_W-1:0] data_m_reg;
    logic [DATA_W-1:0] data_q_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync_m_reg  <= 1'b1;
            sync_q_reg  <= 1'b1;
            async_m_reg <= 1'b1;
            async_q_reg <= 1'b1;
            data_m_reg  <= '0;
            data_q_reg  <= '0;
        end else if (clk_en) begin
            sync_m_reg  <= sync_ready_n;
            sync_q_reg  <= sync_m_reg;
            async_m_reg <= async_ack_n;
            async_q_reg <= async_m_reg;
            data_m_reg  <= data_bus_in;
            data_q_reg  <= data_m_reg;
        end
    end

    // Sequencer state and latched request
    bsq_state_t        state_reg;
    bsq_state_t        state_next;
    logic              ack_seen_reg;
    logic              ack_seen_next;
    logic              wr_reg;
    logic              wr_next;
    logic              virt_reg;
    logic              virt_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic [SIZE_W-1:0] size_reg;
    logic [SIZE_W-1:0] size_next;
    logic [SAS_W-1:0]  sas_reg;
    logic [SAS_W-1:0]  sas_next;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] wdata_next;
    logic              ack_hit;

    assign req_ready = clk_en && (state_reg == ST_IDLE);
    // Sync ready at this state's end, or async caught earlier
    assign ack_hit = ack_seen_reg || !sync_q_reg;

    function automatic logic [SAS_W-1:0] sas_of(input logic wr,
                                                input logic [SAS_W-1:0] code);
        return wr ? SAS_WRITE : code;
    endfunction

    always_comb begin
        state_next    = state_reg;
        ack_seen_next = ack_seen_reg;
        wr_next       = wr_reg;
        virt_next     = virt_reg;
        addr_next     = addr_reg;
        size_next     = size_reg;
        sas_next      = sas_reg;
        wdata_next    = wdata_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (req_valid) begin
                    state_next = ST_P0;
                    wr_next    = req_write;
                    virt_next  = req_virtual;
                    addr_next  = req_addr;
                    size_next  = req_size;
                    sas_next   = sas_of(req_write, req_status);
                    wdata_next = req_wdata;
                end
            end
            ST_P0: state_next = ST_P1;
            ST_P1: state_next = ST_S0;
            ST_S0: state_next = ST_S1;
            ST_S1: state_next = ST_S2;
            ST_S2: begin
                state_next    = ST_S3;
                ack_seen_next = !async_q_reg;
            end
            ST_S3: state_next = ack_hit ? ST_S4 : ST_W1;
            ST_W1: begin
                state_next = ST_W2;
                // Mid-cycle async sample, half a cycle before sync
                if (!async_q_reg) begin
                    ack_seen_next = 1'b1;
                end
            end
            ST_W2: state_next = ack_hit ? ST_S4 : ST_W1;
            ST_S4: state_next = ST_S5;
            ST_S5: begin
                state_next    = ST_V0;
                ack_seen_next = 1'b0;
            end
            ST_V0: state_next = ST_V1;
            ST_V1: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg    <= ST_IDLE;
            ack_seen_reg <= 1'b0;
            wr_reg       <= 1'b0;
            virt_reg     <= 1'b0;
            addr_reg     <= '0;
            size_reg     <= SIZE_RST;
            sas_reg      <= SAS_NOP;
            wdata_reg    <= '0;
        end else if (clk_en) begin
            state_reg    <= state_next;
            ack_seen_reg <= ack_seen_next;
            wr_reg       <= wr_next;
            virt_reg     <= virt_next;
            addr_reg     <= addr_next;
            size_reg     <= size_next;
            sas_reg      <= sas_next;
            wdata_reg    <= wdata_next;
        end
    end

    // Pin outputs, registered from the state being entered
    logic              in_tx;
    logic              in_wait;
    logic              addr_oe_next;
    logic              rw_next;
    logic              ci_n_next;
    logic              as_n_next;
    logic              ds_n_next;
    logic              data_ready_out_n_n_next;
    logic              data_oe_next;
    logic [SAS_W-1:0]  code_next;
    logic              rsp_valid_next;
    logic [DATA_W-1:0] rdata_next;

    always_comb begin
        in_tx = state_next inside {ST_S0, ST_S1, ST_S2, ST_S3, ST_W1, ST_W2,
                                   ST_S4, ST_S5};
        in_wait = state_next inside {ST_W1, ST_W2};
        // Physical mode keeps the address for the whole access
        addr_oe_next = virt_next ? (state_next inside {ST_S0, ST_S1})
                                 : in_tx;
        rw_next   = !(in_tx && wr_next);
        ci_n_next = !(state_next inside {ST_S0, ST_S1, ST_S2, ST_S3});
        as_n_next = !(in_wait || (state_next inside {ST_S1, ST_S2, ST_S3, ST_S4}));
        // Write strobe lags by one cycle so the slave may use either edge
        ds_n_next = wr_next ? !(in_wait || (state_next inside {ST_S3, ST_S4}))
                            : as_n_next;
        data_ready_out_n_n_next  = !(state_next == ST_S5);
        data_oe_next = wr_next && (in_wait || (state_next inside
                       {ST_S2, ST_S3, ST_S4, ST_S5}));
        if (state_next inside {ST_P0, ST_P1, ST_S0, ST_S1, ST_S2, ST_S3,
                               ST_W1, ST_W2}) begin
            code_next = sas_next;
        end else if (state_next != ST_IDLE && req_valid) begin
            code_next = sas_of(req_write, req_status);
        end else begin
            code_next = SAS_NOP;
        end
        rsp_valid_next = (state_reg == ST_S4);
        rdata_next     = rsp_rdata;
        if (state_reg == ST_S4 && !wr_reg) begin
            rdata_next = data_q_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            address_bus_oe     <= 1'b0;
            address_bus_out    <= '0;
            transfer_size      <= SIZE_RST;
            rw_out             <= 1'b1;
            cycle_initiate_n   <= 1'b1;
            addr_strobe_n      <= 1'b1;
            data_strobe_n      <= 1'b1;
            data_ready_out_n   <= 1'b1;
            access_status_code <= SAS_NOP;
            data_bus_out       <= '0;
            data_bus_oe        <= 1'b0;
            rsp_valid          <= 1'b0;
            rsp_rdata          <= '0;
        end else if (clk_en) begin
            address_bus_oe     <= addr_oe_next;
            address_bus_out    <= addr_next;
            transfer_size      <= size_next;
            rw_out             <= rw_next;
            cycle_initiate_n   <= ci_n_next;
            addr_strobe_n      <= as_n_next;
            data_strobe_n      <= ds_n_next;
            data_ready_out_n   <= data_ready_out_n_n_next;
            access_status_code <= code_next;
            data_bus_out       <= wdata_next;
            data_bus_oe        <= data_oe_next;
            rsp_valid          <= rsp_valid_next;
            rsp_rdata          <= rdata_next;
        end
    end

    // Timing checks assume clk_en held high
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst || !clk_en);

    chk_three_cycles: assert property (state_reg == ST_S0 |-> ##3 state_reg == ST_S3)
        else $error("state three not reached in three states");
    chk_zero_wait_end: assert property (state_reg == ST_S3 && ack_hit
        |=> state_reg == ST_S4 ##1 state_reg == ST_S5)
        else $error("acknowledged access did not end");
    chk_vestigial: assert property (state_reg == ST_S5
        |=> (state_reg == ST_V0 && !address_bus_oe) ##1 state_reg == ST_V1)
        else $error("vestigial cycle missing");
    chk_wait_insert: assert property (state_reg == ST_S3 && !ack_seen_reg
        && sync_q_reg |=> state_reg == ST_W1)
        else $error("wait cycle not inserted");
    chk_wait_finish: assert property (state_reg == ST_W2 && ack_hit
        |=> state_reg == ST_S4 ##1 !data_ready_out_n)
        else $error("wait cycle did not finish");
    chk_async_first: assert property (state_reg == ST_S2 && !async_q_reg
        |-> ##2 state_reg == ST_S4)
        else $error("async acknowledge at state two ignored");
    chk_async_mid: assert property (state_reg == ST_W1 && !async_q_reg
        |-> ##2 state_reg == ST_S4)
        else $error("async acknowledge in wait ignored");
    chk_read_start: assert property (state_reg == ST_S0 && !wr_reg
        |-> !cycle_initiate_n && address_bus_oe && rw_out)
        else $error("read start pins wrong");
    chk_read_strobes: assert property (rw_out |-> addr_strobe_n == data_strobe_n)
        else $error("read strobes differ");
    chk_read_capture: assert property (state_reg == ST_S4 && !wr_reg
        |=> rsp_rdata == $past(data_q_reg) && addr_strobe_n && data_strobe_n)
        else $error("read data not captured");
    chk_write_level: assert property (data_bus_oe |-> !rw_out)
        else $error("write data without write level");
    chk_write_code: assert property (state_reg == ST_S0 && wr_reg
        |-> access_status_code == SAS_WRITE)
        else $error("write status code wrong");
    chk_ds_lag: assert property ($fell(addr_strobe_n) && !rw_out
        |-> data_strobe_n ##2 !data_strobe_n)
        else $error("write data strobe lag wrong");
    chk_cycle_init: assert property ($fell(cycle_initiate_n)
        |-> !cycle_initiate_n [*4] ##1 cycle_initiate_n)
        else $error("cycle initiate width wrong");
    chk_virt_release: assert property (state_reg == ST_S2 && virt_reg
        |-> !address_bus_oe)
        else $error("virtual address still driven");
    chk_status_hold: assert property (state_reg == ST_P0
        |-> (access_status_code == sas_reg) [*6])
        else $error("status code not held");
    // Idle request means no-operation code once state four is reached
    chk_code_release: assert property (state_reg == ST_S4 && !$past(req_valid)
        |-> access_status_code == SAS_NOP)
        else $error("status code not released at state four");
    chk_data_ready_out_n_pulse: assert property (state_reg == ST_S5
        |-> !data_ready_out_n ##1 data_ready_out_n)
        else $error("data ready pulse wrong");
    chk_wait_stable: assert property (state_reg == ST_W1
        |=> $stable(address_bus_out) && $stable(addr_strobe_n)
            && $stable(data_strobe_n) && $stable(data_bus_out))
        else $error("outputs moved in wait");

    cov_read_zero: cover property (state_reg == ST_S3 && ack_hit && !wr_reg);
    cov_write_wait: cover property (state_reg == ST_W2 && wr_reg);
    cov_async_wait: cover property (state_reg == ST_W1 && !async_q_reg);
    cov_two_waits: cover property (state_reg == ST_W2 ##1 state_reg == ST_W1);
    cov_virt_read: cover property (state_reg == ST_S2 && virt_reg && !wr_reg);

endmodule // bsq_sequencer
`default_nettype wire

// File: bsq_slave_model.sv
// Behavioural memory slave answering the sequencer bus
`timescale 1ns/1ps
`default_nettype none
module bsq_slave_model
    import bsq_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              cycle_initiate_n,
    input  wire logic              addr_strobe_n,
    input  wire logic              data_strobe_n,
    input  wire logic              rw_out,
    input  wire logic [DATA_W-1:0] data_bus_out,
    input  wire logic              use_async,
    input  wire logic [3:0]        ack_delay,
    input  wire logic [DATA_W-1:0] rd_word,
    output logic                   sync_ready_n,
    output logic                   async_ack_n,
    output logic [DATA_W-1:0]      data_bus_in,
    output logic [DATA_W-1:0]      wr_word
);
    int   k = 100;
    logic ci_q = 1'b1;
    logic ds_q = 1'b1;
    logic ack;
    initial begin
        sync_ready_n = 1'b1;
        async_ack_n = 1'b1;
        data_bus_in = '0;
        wr_word = '0;
    end
    // Clocks counted from the first cycle-initiate state
    always @(negedge ref_clk) begin
        k = (!cycle_initiate_n && ci_q) ? 0 : k + 1;
        ci_q = cycle_initiate_n;
        ack = (!cycle_initiate_n || !addr_strobe_n) && (k >= ack_delay);
        async_ack_n <= !(ack && use_async);
        sync_ready_n <= !(ack && !use_async);
        // Undriven bus toggles between ~rd_word and rd_word on each clock
        data_bus_in <= ack ? rd_word : ~rd_word ^ {DATA_W{k[0]}};
        if (data_strobe_n && !ds_q && !rw_out) wr_word <= data_bus_out;
        ds_q = data_strobe_n;
    end
endmodule // bsq_slave_model
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the bus read/write sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bsq_pkg::*;
    logic              ref_clk = 1'b0;
    logic              sys_rst, req_valid, req_write, req_virtual, use_async;
    logic              req_ready, rsp_valid, addr_oe, rw_out, ci_n, as_n, ds_n, data_ready_out_n_n;
    logic              dbus_oe, sync_n, async_n, ci_q = 1'b1, clk_en = 1'b1;
    logic [ADDR_W-1:0] req_addr, addr_out;
    logic [DATA_W-1:0] req_wdata, rd_word, rsp_rdata, dbus_in, dbus_out, wr_word, rdat_q;
    logic [SIZE_W-1:0] req_size, size_out;
    logic [SAS_W-1:0]  req_status, code, code_q, code_s0, code_lead;
    logic [3:0]        ack_delay;
    logic [31:0]       lfsr_q = 32'h2961;
    int                num_errors = 0;
    int                comparisons = 0;
    int                ci_c, as_c, ds_c, lag_c, aoe_c, dr_c, rv_c, bad_c, gap_c;
    int                idle_run = 99;

    bsq_sequencer dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_virtual(req_virtual), .req_addr(req_addr), .req_size(req_size),
        .req_status(req_status), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .address_bus_out(addr_out), .address_bus_oe(addr_oe),
        .transfer_size(size_out), .rw_out(rw_out), .cycle_initiate_n(ci_n),
        .addr_strobe_n(as_n), .data_strobe_n(ds_n), .data_ready_out_n(data_ready_out_n_n),
        .access_status_code(code), .data_bus_in(dbus_in), .data_bus_out(dbus_out),
        .data_bus_oe(dbus_oe), .sync_ready_n(sync_n), .async_ack_n(async_n));

    bsq_slave_model slave (.ref_clk(ref_clk), .cycle_initiate_n(ci_n),
        .addr_strobe_n(as_n), .data_strobe_n(ds_n), .rw_out(rw_out),
        .data_bus_out(dbus_out), .use_async(use_async), .ack_delay(ack_delay),
        .rd_word(rd_word), .sync_ready_n(sync_n), .async_ack_n(async_n),
        .data_bus_in(dbus_in), .wr_word(wr_word));

    always #10 ref_clk = ~ref_clk;

    function automatic logic [31:0] lfsr_next();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction

    // Async is sampled half a cycle before sync, so it must arrive one state earlier
    function automatic int exp_waits(input logic asy, input logic [3:0] dly);
        return asy ? (int'(dly) + 1) / 2 : int'(dly) / 2;
    endfunction

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Pin tallies; cleared by xfer on a rising edge to avoid racing this block
    always @(negedge ref_clk) begin
        if (!ci_n && ci_q) begin
            gap_c = idle_run;
            code_lead = code_q;
            code_s0 = code;
        end
        idle_run = (ci_n && as_n) ? idle_run + 1 : 0;
        ci_c += !ci_n;
        as_c += !as_n;
        ds_c += !ds_n;
        lag_c += (!ds_n && as_n);
        aoe_c += addr_oe;
        if (!ci_n || !as_n) bad_c += (rw_out !== !req_write) || (size_out !== req_size);
        if (!as_n && !req_virtual) bad_c += (addr_oe !== 1'b1);
        if (addr_oe) bad_c += (addr_out !== req_addr);
        if (!ds_n && req_write) bad_c += (dbus_oe !== 1'b1) || (dbus_out !== req_wdata);
        if (!req_write) bad_c += (dbus_oe !== 1'b0);
        if (!data_ready_out_n_n) bad_c += (code !== SAS_NOP);
        // Counts are two-state, so unknown pins are caught here
        bad_c += $isunknown({ci_n, as_n, ds_n, data_ready_out_n_n, rw_out, addr_oe, dbus_oe, rsp_valid, code});
        dr_c += !data_ready_out_n_n;
        rv_c += rsp_valid;
        if (rsp_valid) rdat_q = rsp_rdata;
        ci_q = ci_n;
        code_q = code;
    end

    task automatic xfer(input logic wr, vt, asy, input logic [3:0] dly,
                        input logic [31:0] a, wd, rd);
        int          n;
        int          i;
        logic [31:0] r;
        logic [31:0] cx;
        r = lfsr_next();
        n = exp_waits(asy, dly);
        cx = wr ? {28'h0, SAS_WRITE} : {28'h0, r[5:2]};
        @(posedge ref_clk);
        {ci_c, as_c, ds_c, lag_c, aoe_c, dr_c, rv_c, bad_c} = '0;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_virtual = vt;
        use_async = asy;
        ack_delay = dly;
        req_addr = a;
        req_wdata = wd;
        rd_word = rd;
        req_size = r[1:0];
        req_status = r[5:2];
        for (i = 0; i < 40 && req_ready !== 1'b1; i++) @(negedge ref_clk);
        @(negedge ref_clk);
        req_valid = 1'b0;
        check_word({31'h0, req_ready}, 32'h0);
        for (i = 0; i < 80 && rv_c == 0; i++) @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
        check_count(ci_c, CI_STATES);
        check_count(as_c, CI_STATES + n * STATES_PER_CYCLE);
        check_count(ds_c, CI_STATES + n * STATES_PER_CYCLE - (wr ? DS_LAG_STATES : 0));
        check_count(lag_c, 0);
        check_count(bad_c, 0);
        check_count(int'(gap_c >= 2 * STATES_PER_CYCLE), 1);
        check_count(dr_c, 1);
        check_count(rv_c, 1);
        if (vt) check_count(aoe_c, STATES_PER_CYCLE);
        check_word({28'h0, code_s0}, cx);
        check_word({28'h0, code_lead}, cx);
        check_word(wr ? wr_word : rdat_q, wr ? wd : rd);
    endtask

    initial begin
        int          k;
        logic [31:0] r;
        sys_rst = 1'b1;
        req_valid = 1'b0;
        {req_write, req_virtual, use_async, ack_delay} = '0;
        {req_addr, req_wdata, rd_word, req_size, req_status} = '0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check_word({25'h0, ci_n, as_n, ds_n, data_ready_out_n_n, rw_out, addr_oe, dbus_oe}, 32'h0000_007C);
        sys_rst = 1'b0;
        xfer(1'b0, 1'b0, 1'b0, 4'h1, 32'h0000_1000, 32'h0, 32'hA5A5_5A5A);
        xfer(1'b0, 1'b0, 1'b1, 4'h0, 32'h0000_2004, 32'h0, 32'h1234_5678);
        xfer(1'b1, 1'b0, 1'b0, 4'h1, 32'hFFFF_FFFC, 32'hDEAD_BEEF, 32'h0);
        xfer(1'b1, 1'b0, 1'b1, 4'h0, 32'h0000_0000, 32'h0F0F_F0F0, 32'h0);
        xfer(1'b0, 1'b1, 1'b1, 4'h3, 32'h8000_0010, 32'h0, 32'hFFFF_0000);
        xfer(1'b1, 1'b0, 1'b0, 4'h4, 32'h0000_0100, 32'h5555_AAAA, 32'h0);
        xfer(1'b1, 1'b1, 1'b1, 4'h1, 32'h0000_0040, 32'h0123_4567, 32'h0);
        for (k = 0; k < 20; k++) begin
            r = lfsr_next();
            xfer(r[0], r[1], r[2], {1'b0, r[5:3]}, lfsr_next(), lfsr_next(), lfsr_next());
        end
        // Low clock enable holds the access in state one; then reset mid-transfer
        @(negedge ref_clk);
        req_valid = 1'b1;
        repeat (4) @(negedge ref_clk);
        clk_en = 1'b0;
        repeat (3) @(negedge ref_clk);
        check_word({31'h0, req_ready}, 32'h0);
        check_word({21'h0, ci_n, as_n, ds_n, data_ready_out_n_n, rw_out, addr_oe, dbus_oe, code},
                   {21'h0, 2'b00, req_write, 1'b1, !req_write, 2'b10,
                    req_write ? SAS_WRITE : req_status});
        clk_en = 1'b1;
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b1;
        @(negedge ref_clk);
        check_word({25'h0, ci_n, as_n, ds_n, data_ready_out_n_n, rw_out, addr_oe, dbus_oe}, 32'h0000_007C);
        sys_rst = 1'b0;
        req_valid = 1'b0;
        xfer(1'b0, 1'b0, 1'b0, 4'h2, 32'h0000_3000, 32'h0, 32'hC3C3_3C3C);
        tally_and_finish();
    end

    initial begin
        #100000;
        num_errors++;
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
